/* verilog/olpm_pkg.sv */
package olpm_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADR_INSTR = 8'h00;
  localparam logic [7:0] ADR_WREG = 8'h04;
  localparam logic [7:0] ADR_BANK = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_PTR0 = 8'h10;
  localparam logic [7:0] ADR_MADDR = 8'h1c;
  localparam logic [7:0] ADR_MDATA = 8'h20;
  localparam logic [7:0] ADR_STEP = 8'h04;

  // Widths and counts
  localparam int DATA_AW = 12;
  localparam int BANK_W = 4;
  localparam int PTR_W = 12;
  localparam int PTR_N = 3;

  // Opcode fields
  localparam logic [5:0] OPC_OR = 6'h04;
  localparam logic [5:0] OPC_MOV = 6'h14;
  localparam logic [9:0] OPC_LPTR = 10'h3b8;
  localparam logic [7:0] OPC_LPTR2 = 8'hf0;

  // Access bank split: low part maps to bank 0, upper part to top bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // Status bit positions
  localparam int ST_Z = 0;
  localparam int ST_N = 1;
  localparam int ST_ILL = 7;
  localparam int ST_WAIT = 8;

  // Reset values
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_PTR = 12'h000;
  localparam logic [11:0] RST_MADDR = 12'h000;

  typedef enum logic [1:0] {OP_NONE, OP_OR, OP_MOV, OP_LPTR} olpm_op_e;

  typedef struct packed {
    olpm_op_e op;
    logic dest;
    logic bank;
    logic [7:0] file;
    logic [1:0] ptr;
    logic [3:0] khi;
  } olpm_dec_s;

endpackage

/* verilog/olpm_data_ram.sv */
`timescale 1ns/1ps
module olpm_data_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk_i,
  // Single port
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // Read-first: a write shows old data on the same edge
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end

endmodule

/* verilog/olpm_core.sv */
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module olpm_core #(
  parameter logic [7:0] ACCESS_SPLIT = olpm_pkg::ACCESS_SPLIT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core state
  output logic busy_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT2} olpm_state_e;

  function automatic olpm_pkg::olpm_dec_s decode(input logic [15:0] word);
    olpm_pkg::olpm_dec_s r;
    r = '0;
    r.op = olpm_pkg::OP_NONE;
    r.dest = word[9];
    r.bank = word[8];
    r.file = word[7:0];
    r.ptr = word[5:4];
    r.khi = word[3:0];
    if (word[15:10] == olpm_pkg::OPC_OR) begin
      r.op = olpm_pkg::OP_OR;
    end else if (word[15:10] == olpm_pkg::OPC_MOV) begin
      r.op = olpm_pkg::OP_MOV;
    end else if (word[15:6] == olpm_pkg::OPC_LPTR) begin
      r.op = olpm_pkg::OP_LPTR;
    end
    return r;
  endfunction

  function automatic logic [11:0] data_addr(input logic bank,
                                            input logic [7:0] file,
                                            input logic [3:0] bsel);
    logic [3:0] hi;
    if (bank) begin
      hi = bsel;
    end else if (file < ACCESS_SPLIT) begin
      hi = olpm_pkg::ACCESS_LO_BANK;
    end else begin
      hi = olpm_pkg::ACCESS_HI_BANK;
    end
    return {hi, file};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  olpm_state_e state_q, state_d;
  olpm_pkg::olpm_dec_s ex_q, ex_d, dec;
  logic [11:0] ex_addr_q, ex_addr_d;
  logic [7:0] w_q, w_d;
  logic [3:0] bank_q, bank_d;
  logic nf_q, nf_d, zf_q, zf_d, ill_q, ill_d;
  logic [2:0][11:0] ptr_q, ptr_d;
  logic [11:0] maddr_q, maddr_d;
  logic [15:0] instr_q, instr_d;
  logic ack_q, ack_d, pend_q, pend_d;
  logic busy_q, busy_d;
  logic [31:0] dat_q, dat_d;
  logic ram_we;
  logic [11:0] ram_addr;
  logic [7:0] ram_wd, ram_rd, res;
  logic [15:0] m16;
  logic req, mdata_rd, hold, acc, wr;
  logic [7:0] adr;

  olpm_data_ram #(
    .AW(olpm_pkg::DATA_AW),
    .DW(8)
  ) u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(ram_wd),
    .rdata_o(ram_rd)
  );

  assign adr = {wb_adr_i[7:2], 2'b00};
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign mdata_rd = req & ~wb_we_i & (adr == olpm_pkg::ADR_MDATA);
  // Execute cycle owns the RAM port; memory reads need one cycle of latency
  assign hold = (state_q == ST_EXEC) | (mdata_rd & ~pend_q);
  assign acc = req & ~hold;
  assign wr = acc & wb_we_i;
  assign dec = decode(wb_dat_i[15:0]);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign busy_o = busy_q;

  always_comb begin
    state_d = state_q;
    ex_d = ex_q;
    ex_addr_d = ex_addr_q;
    w_d = w_q;
    bank_d = bank_q;
    nf_d = nf_q;
    zf_d = zf_q;
    ill_d = ill_q;
    ptr_d = ptr_q;
    maddr_d = maddr_q;
    instr_d = instr_q;
    ram_we = 1'b0;
    ram_addr = maddr_q;
    ram_wd = wb_dat_i[7:0];
    res = ram_rd;
    m16 = '0;
    if (state_q == ST_EXEC) begin
      if (ex_q.op == olpm_pkg::OP_OR) begin
        res = w_q | ram_rd;
      end
      nf_d = res[7];
      zf_d = (res == 8'h00);
      if (ex_q.dest) begin
        ram_we = 1'b1;
        ram_addr = ex_addr_q;
        ram_wd = res;
      end else begin
        w_d = res;
      end
      state_d = ST_IDLE;
    end
    if (wr) begin
      case (adr)
        olpm_pkg::ADR_INSTR: begin
          instr_d = wb_dat_i[15:0];
          if (state_q == ST_WAIT2) begin
            // Whatever comes next is the second word; a bad one is dropped
            if (wb_dat_i[15:8] == olpm_pkg::OPC_LPTR2) begin
              ptr_d[ex_q.ptr][7:0] = wb_dat_i[7:0];
            end else begin
              ill_d = 1'b1;
            end
            state_d = ST_IDLE;
          end else begin
            case (dec.op)
              olpm_pkg::OP_OR, olpm_pkg::OP_MOV: begin
                ex_d = dec;
                ex_addr_d = data_addr(dec.bank, dec.file, bank_q);
                ram_addr = ex_addr_d;
                state_d = ST_EXEC;
              end
              olpm_pkg::OP_LPTR: begin
                if (dec.ptr < 2'(olpm_pkg::PTR_N)) begin
                  ptr_d[dec.ptr][11:8] = dec.khi;
                  ex_d = dec;
                  state_d = ST_WAIT2;
                end else begin
                  ill_d = 1'b1;
                end
              end
              default: begin
                ill_d = 1'b1;
              end
            endcase
          end
        end
        olpm_pkg::ADR_WREG: begin
          m16 = merge16({8'h00, w_q}, wb_dat_i, wb_sel_i);
          w_d = m16[7:0];
        end
        olpm_pkg::ADR_BANK: begin
          m16 = merge16({12'h000, bank_q}, wb_dat_i, wb_sel_i);
          bank_d = m16[3:0];
        end
        olpm_pkg::ADR_STATUS: begin
          if (wb_sel_i[0]) begin
            zf_d = wb_dat_i[olpm_pkg::ST_Z];
            nf_d = wb_dat_i[olpm_pkg::ST_N];
            if (wb_dat_i[olpm_pkg::ST_ILL]) begin
              ill_d = 1'b0;
            end
          end
        end
        olpm_pkg::ADR_MADDR: begin
          m16 = merge16({4'h0, maddr_q}, wb_dat_i, wb_sel_i);
          maddr_d = m16[11:0];
        end
        olpm_pkg::ADR_MDATA: begin
          ram_we = wb_sel_i[0];
        end
        default: begin
          for (int i = 0; i < olpm_pkg::PTR_N; i++) begin
            if (adr == olpm_pkg::ADR_PTR0 + 8'(i) * olpm_pkg::ADR_STEP) begin
              m16 = merge16({4'h0, ptr_q[i]}, wb_dat_i, wb_sel_i);
              ptr_d[i] = m16[11:0];
            end
          end
        end
      endcase
    end
    // Registered so the pin shows no glitch while the next state settles
    busy_d = (state_d != ST_IDLE);
  end

  // Bus answer: ack, read latency and read data
  always_comb begin
    ack_d = acc;
    // A memory read waits one cycle for the registered RAM output
    pend_d = mdata_rd & ~pend_q & (state_q != ST_EXEC);
    dat_d = dat_q;
    if (acc & ~wb_we_i) begin
      dat_d = '0;
      case (adr)
        olpm_pkg::ADR_INSTR: dat_d[15:0] = instr_q;
        olpm_pkg::ADR_WREG: dat_d[7:0] = w_q;
        olpm_pkg::ADR_BANK: dat_d[3:0] = bank_q;
        olpm_pkg::ADR_STATUS: begin
          dat_d[olpm_pkg::ST_Z] = zf_q;
          dat_d[olpm_pkg::ST_N] = nf_q;
          dat_d[olpm_pkg::ST_ILL] = ill_q;
          dat_d[olpm_pkg::ST_WAIT] = (state_q == ST_WAIT2);
        end
        olpm_pkg::ADR_MADDR: dat_d[11:0] = maddr_q;
        olpm_pkg::ADR_MDATA: dat_d[7:0] = ram_rd;
        default: begin
          for (int i = 0; i < olpm_pkg::PTR_N; i++) begin
            if (adr == olpm_pkg::ADR_PTR0 + 8'(i) * olpm_pkg::ADR_STEP) begin
              dat_d[11:0] = ptr_q[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      ex_q <= '0;
      ex_addr_q <= '0;
      w_q <= olpm_pkg::RST_WREG;
      bank_q <= olpm_pkg::RST_BANK;
      nf_q <= 1'b0;
      zf_q <= 1'b0;
      ill_q <= 1'b0;
      ptr_q <= {olpm_pkg::PTR_N{olpm_pkg::RST_PTR}};
      maddr_q <= olpm_pkg::RST_MADDR;
      instr_q <= '0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ex_q <= ex_d;
      ex_addr_q <= ex_addr_d;
      w_q <= w_d;
      bank_q <= bank_d;
      nf_q <= nf_d;
      zf_q <= zf_d;
      ill_q <= ill_d;
      ptr_q <= ptr_d;
      maddr_q <= maddr_d;
      instr_q <= instr_d;
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= ack_d;
      pend_q <= pend_d;
      dat_q <= dat_d;
    end
  end

endmodule

/* testbench/olpm_fetch_model.sv */
`timescale 1ns/1ps
module olpm_fetch_model (
  // Program counter
  input wire logic [3:0] pc_i,
  // Instruction word
  output logic [15:0] word_o
);
  always_comb begin
    case (pc_i)
      4'h0: word_o = 16'h1113;
      4'h1: word_o = 16'h1285;
      4'h2: word_o = 16'h5013;
      4'h3: word_o = 16'h53ff;
      // Pointer index 3 does not exist
      default: word_o = 16'hee31;
    endcase
  end
endmodule

/* testbench/olpm_core_props.sv */
`timescale 1ns/1ps
module olpm_core_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Core state
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic iw;
  assign iw = wb_ack_o && wb_we_i && wb_adr_i == olpm_pkg::ADR_INSTR;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  ack_bound_a: assert property ($rose(wb_stb_i) |-> ##[1:3] wb_ack_o)
    else $error("ack late");
  or_exec_a: assert property (iw && !$past(busy_o) &&
    wb_dat_i[15:10] == olpm_pkg::OPC_OR |-> busy_o ##1 !busy_o)
    else $error("or cycle wrong");
  mov_exec_a: assert property (iw && !$past(busy_o) &&
    wb_dat_i[15:10] == olpm_pkg::OPC_MOV |-> busy_o ##1 !busy_o)
    else $error("move cycle wrong");
  lptr_wait_a: assert property (iw && !$past(busy_o) &&
    wb_dat_i[15:6] == olpm_pkg::OPC_LPTR && wb_dat_i[5:4] != 2'h3
    |=> busy_o [*2]) else $error("no second word wait");
  lptr_done_a: assert property (iw && $past(busy_o) &&
    wb_dat_i[15:8] == olpm_pkg::OPC_LPTR2 |-> ##[1:2] !busy_o)
    else $error("second word not ending");
  bad_index_a: assert property (iw && !$past(busy_o) &&
    wb_dat_i[15:4] == {olpm_pkg::OPC_LPTR, 2'h3} |=> !busy_o)
    else $error("index 3 waits");
  cover property (iw && wb_dat_i[15:10] == olpm_pkg::OPC_OR);
  cover property (iw && wb_dat_i[15:10] == olpm_pkg::OPC_MOV);
  cover property (iw && wb_dat_i[15:8] == olpm_pkg::OPC_LPTR2);
endmodule
bind olpm_core olpm_core_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic busy_o;
  logic [3:0] pc = 4'h0;
  logic [15:0] word;
  logic [11:0] k;
  int error_cnt = 0;
  int checks = 0;
  always #50 clk_i = ~clk_i;
  olpm_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busy_o(busy_o));
  olpm_fetch_model u_fetch (.pc_i(pc), .word_o(word));
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // No limit here: a lost ack is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic mset(input logic [11:0] a, input logic [7:0] v);
    xfer(1'b1, olpm_pkg::ADR_MADDR, {20'h0, a});
    xfer(1'b1, olpm_pkg::ADR_MDATA, {24'h0, v});
  endtask
  task automatic mchk(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b1, olpm_pkg::ADR_MADDR, {20'h0, a});
    chk(olpm_pkg::ADR_MDATA, {24'h0, e});
  endtask
  task automatic run(input logic [3:0] n);
    pc = n;
    @(negedge clk_i);
    xfer(1'b1, olpm_pkg::ADR_INSTR, {16'h0, word});
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(olpm_pkg::ADR_WREG, 32'h0);
    xfer(1'b1, olpm_pkg::ADR_WREG, 32'h91);
    xfer(1'b1, olpm_pkg::ADR_BANK, 32'h2);
    mset(12'h213, 8'h13);
    run(4'h0);
    chk(olpm_pkg::ADR_WREG, 32'h93);
    chk(olpm_pkg::ADR_STATUS, 32'h2);
    mchk(12'h213, 8'h13);
    xfer(1'b1, olpm_pkg::ADR_WREG, 32'h05);
    mset(12'hf85, 8'h40);
    run(4'h1);
    mchk(12'hf85, 8'h45);
    chk(olpm_pkg::ADR_WREG, 32'h05);
    chk(olpm_pkg::ADR_STATUS, 32'h0);
    mset(12'h013, 8'h00);
    run(4'h2);
    chk(olpm_pkg::ADR_WREG, 32'h0);
    chk(olpm_pkg::ADR_STATUS, 32'h1);
    mset(12'h2ff, 8'h80);
    run(4'h3);
    chk(olpm_pkg::ADR_WREG, 32'h0);
    mchk(12'h2ff, 8'h80);
    chk(olpm_pkg::ADR_STATUS, 32'h2);
    for (int p = 0; p < 3; p++) begin
      k = 12'h3ab + 12'(p * 12'h111);
      xfer(1'b1, olpm_pkg::ADR_STATUS, 32'h3);
      xfer(1'b1, olpm_pkg::ADR_INSTR, {16'h0, 10'h3b8, 2'(p), k[11:8]});
      xfer(1'b0, 8'(olpm_pkg::ADR_PTR0 + 8'h4 * p), 32'h0);
      `CHK(rd[11:8], k[11:8])
      chk(olpm_pkg::ADR_STATUS, 32'h103);
      `CHK(busy_o, 1'b1)
      xfer(1'b1, olpm_pkg::ADR_INSTR, {16'h0, 8'hf0, k[7:0]});
      chk(8'(olpm_pkg::ADR_PTR0 + 8'h4 * p), {20'h0, k});
      chk(olpm_pkg::ADR_STATUS, 32'h3);
      `CHK(busy_o, 1'b0)
    end
    run(4'h4);
    chk(olpm_pkg::ADR_STATUS, 32'h83);
    chk(olpm_pkg::ADR_PTR0, 32'h3ab);
    xfer(1'b1, olpm_pkg::ADR_STATUS, 32'h80);
    chk(olpm_pkg::ADR_STATUS, 32'h0);
    chk(8'h24, 32'h0);
    xfer(1'b1, olpm_pkg::ADR_INSTR, 32'hee17);
    xfer(1'b1, olpm_pkg::ADR_INSTR, 32'h1234);
    chk(olpm_pkg::ADR_STATUS, 32'h80);
    chk(olpm_pkg::ADR_PTR0 + 8'h4, 32'h7bc);
    xfer(1'b1, olpm_pkg::ADR_WREG, 32'h5a);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(olpm_pkg::ADR_WREG, 32'h0);
    chk(olpm_pkg::ADR_STATUS, 32'h0);
    chk(olpm_pkg::ADR_PTR0 + 8'h4, 32'h0);
    tally_and_finish;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish;
  end
endmodule
